// *** wdcm_pkg.sv ***
// Purpose: shared constants for the watchdog with clock-fail reset
// Assumes: core clock of 50 MHz, internal rc oscillator seen as a pin
// Notes: register offsets index an 8-bit register port
package wdcm_pkg;
	// register offsets
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_FLAGS = 4'h1;
	localparam logic [3:0] ADDR_CLR = 4'h2;
	localparam logic [3:0] ADDR_EN = 4'h3;
	// wdog_control_reg fields
	localparam int CTRL_SOFT_EN = 0;
	localparam int CTRL_PD = 3;
	localparam int CTRL_TO = 4;
	localparam int CTRL_FAILSAFE = 5;
	localparam int CTRL_CORE_LVL = 6;
	// periph_irq_flags_2 fields
	localparam int FLAG_WDOG_TO = 0;
	localparam int FLAG_OSC_FAIL = 7;
	// reset values
	localparam logic [7:0] RST_IRQ_EN = 8'h00;
	localparam logic RST_SOFT_EN = 1'b0;
	// timing: base period and nominal rc oscillator period
	localparam int BASE_TIME_US = 4000;
	localparam int RC_PERIOD_NS = 32000;
	localparam int BASE_TICKS = (BASE_TIME_US * 1000) / RC_PERIOD_NS;
	localparam int PS_WIDTH = 16;
	localparam int SEL_WIDTH = 4;
endpackage

// *** wdcm_top.sv ***
// Purpose: watchdog timer on the internal rc oscillator plus fail-safe clock monitor
// Assumes: rc oscillator, sample clock, monitor latch and core level arrive as pins
// Notes: all state lives in one struct; i_ce low freezes everything
//
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps

// Behaviour
// - watchdog counts rc oscillator rising edges; enabling it turns the oscillator on
// - base time period is nominally 4 ms of rc oscillator ticks
// - base period feeds a 16-bit postscaler setting the time-out
// - postscale-select input picks which postscaler output ends the count
// - time-out spans about 4 ms to about 131 seconds
// - sleep or clear-watchdog instruction clears counter and postscaler
// - enabled watchdog keeps counting in run, idle and sleep modes
// - software enable bit in the control register turns the watchdog on or off
// - software enable only matters when configuration enable is off
// - control register shows live core-voltage level, valid with regulator on
// - clock failure checked at sample clock falling edge with monitor latch set
// - clock failure sets oscillator-fail flag in bit 7 of the irq flags
// - clock failure switches to internal oscillator; oscillator control not updated
// - clock failure clears the watchdog counter and postscaler
// - only primary and secondary source failures are detected
// - rc oscillator stays on for the clock monitor when watchdog is off
// - reaching the selected time-out generates a device reset
module wdcm_top #(
	parameter int BASE_TICKS = wdcm_pkg::BASE_TICKS
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic [3:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_clear_wdog_instruction,
	input wire logic i_sleep_instruction,
	input wire logic i_config_wdog_enable,
	input wire logic [wdcm_pkg::SEL_WIDTH-1:0] i_wdog_postscale_select,
	input wire logic i_fail_safe_clock_monitor_enable,
	input wire logic i_clk_src_is_intosc,
	input wire logic i_regulator_enable,
	input wire logic i_internal_rc_osc,
	input wire logic i_sample_clk,
	input wire logic i_monitor_latch,
	input wire logic i_core_supply_level,
	output logic [7:0] o_rdata,
	output logic o_device_reset,
	output logic o_rc_osc_enable,
	output logic o_use_internal_osc,
	output logic o_timeout_status_flag,
	output logic o_powerdown_status_flag,
	output logic o_irq
);
	localparam int PW = wdcm_pkg::PS_WIDTH;

	typedef struct packed {
		logic [2:0] rc_sync;
		logic [2:0] smp_sync;
		logic [2:0] lat_sync;
		logic [2:0] lvl_sync;
		logic rc_lvl;
		logic smp_lvl;
		logic lat_lvl;
		logic core_lvl;
		logic [15:0] base_cnt;
		logic [PW-1:0] ps_cnt;
		logic soft_en;
		logic failsafe;
		logic [7:0] irq_stat;
		logic [7:0] irq_en;
		logic to_flag;
		logic pd_flag;
		logic rst_out;
		logic rc_en;
		logic irq;
		logic [7:0] rdata;
	} wdcm_state_t;

	wdcm_state_t st_ff;
	wdcm_state_t nxt_st;

	// postscaler terminal count for a power-of-two ratio
	function automatic logic [PW-1:0] wdcm_ps_limit(input logic [wdcm_pkg::SEL_WIDTH-1:0] sel);
		logic [PW:0] one_hot;
		one_hot = (PW+1)'(1) << sel;
		return PW'(one_hot - (PW+1)'(1));
	endfunction

	// agreed level of a three-stage synchroniser: update once stages two and three agree
	function automatic logic wdcm_agree(input logic [2:0] sync, input logic cur);
		return (sync[1] == sync[2]) ? sync[2] : cur;
	endfunction

	logic wd_en;
	logic rc_tick;
	logic smp_fall;
	logic fail_det;
	logic base_end;
	logic timeout;
	logic ctr_clear;
	logic [7:0] ev_set;
	logic [7:0] ctrl_rd;

	// event decode shared by the next-state logic and the checks
	always_comb
	begin
		wd_en = i_config_wdog_enable | st_ff.soft_en;
		rc_tick = wdcm_agree(st_ff.rc_sync, st_ff.rc_lvl) & ~st_ff.rc_lvl;
		smp_fall = ~wdcm_agree(st_ff.smp_sync, st_ff.smp_lvl) & st_ff.smp_lvl;
		// failure only while running from an external source
		fail_det = smp_fall & st_ff.lat_lvl & i_fail_safe_clock_monitor_enable
			& ~i_clk_src_is_intosc & ~st_ff.failsafe;
		base_end = st_ff.base_cnt == 16'(BASE_TICKS - 1);
		ctr_clear = i_clear_wdog_instruction | i_sleep_instruction | fail_det | ~wd_en;
		timeout = wd_en & rc_tick & base_end & ~ctr_clear
			& (st_ff.ps_cnt == wdcm_ps_limit(i_wdog_postscale_select));
		ev_set = 8'h00;
		ev_set[wdcm_pkg::FLAG_WDOG_TO] = timeout;
		ev_set[wdcm_pkg::FLAG_OSC_FAIL] = fail_det;
		ctrl_rd = 8'h00;
		ctrl_rd[wdcm_pkg::CTRL_SOFT_EN] = st_ff.soft_en;
		ctrl_rd[wdcm_pkg::CTRL_PD] = st_ff.pd_flag;
		ctrl_rd[wdcm_pkg::CTRL_TO] = st_ff.to_flag;
		ctrl_rd[wdcm_pkg::CTRL_FAILSAFE] = st_ff.failsafe;
		ctrl_rd[wdcm_pkg::CTRL_CORE_LVL] = st_ff.core_lvl & i_regulator_enable;
	end

	// next state
	always_comb
	begin
		nxt_st = st_ff;
		// pin synchronisers, first stage read only by the second
		nxt_st.rc_sync = {st_ff.rc_sync[1:0], i_internal_rc_osc};
		nxt_st.smp_sync = {st_ff.smp_sync[1:0], i_sample_clk};
		nxt_st.lat_sync = {st_ff.lat_sync[1:0], i_monitor_latch};
		nxt_st.lvl_sync = {st_ff.lvl_sync[1:0], i_core_supply_level};
		nxt_st.rc_lvl = wdcm_agree(st_ff.rc_sync, st_ff.rc_lvl);
		nxt_st.smp_lvl = wdcm_agree(st_ff.smp_sync, st_ff.smp_lvl);
		nxt_st.lat_lvl = wdcm_agree(st_ff.lat_sync, st_ff.lat_lvl);
		nxt_st.core_lvl = wdcm_agree(st_ff.lvl_sync, st_ff.core_lvl);
		// watchdog counting, the same in run, idle and sleep
		if (ctr_clear || timeout)
		begin
			nxt_st.base_cnt = 16'h0000;
			nxt_st.ps_cnt = '0;
		end
		else if (rc_tick)
		begin
			if (base_end)
			begin
				nxt_st.base_cnt = 16'h0000;
				nxt_st.ps_cnt = st_ff.ps_cnt + PW'(1);
			end
			else
			begin
				nxt_st.base_cnt = st_ff.base_cnt + 16'h0001;
			end
		end
		nxt_st.rst_out = timeout;
		// fail-safe mode holds until reset; the oscillator control is left alone
		if (fail_det)
		begin
			nxt_st.failsafe = 1'b1;
		end
		// status flags
		if (timeout)
		begin
			nxt_st.to_flag = 1'b0;
		end
		else if (i_clear_wdog_instruction)
		begin
			nxt_st.to_flag = 1'b1;
			nxt_st.pd_flag = 1'b1;
		end
		else if (i_sleep_instruction)
		begin
			nxt_st.to_flag = 1'b1;
			nxt_st.pd_flag = 1'b0;
		end
		// register writes; a set in the clear cycle wins
		nxt_st.irq_stat = st_ff.irq_stat | ev_set;
		if (i_wr)
		begin
			case (i_addr)
				wdcm_pkg::ADDR_CTRL: nxt_st.soft_en = i_wdata[wdcm_pkg::CTRL_SOFT_EN];
				wdcm_pkg::ADDR_CLR: nxt_st.irq_stat = (st_ff.irq_stat & ~i_wdata) | ev_set;
				wdcm_pkg::ADDR_EN: nxt_st.irq_en = i_wdata;
				default: nxt_st.irq_en = st_ff.irq_en;
			endcase
		end
		// read data one cycle after the strobe, zero otherwise
		nxt_st.rdata = 8'h00;
		if (i_rd)
		begin
			case (i_addr)
				wdcm_pkg::ADDR_CTRL: nxt_st.rdata = ctrl_rd;
				wdcm_pkg::ADDR_FLAGS: nxt_st.rdata = st_ff.irq_stat;
				wdcm_pkg::ADDR_EN: nxt_st.rdata = st_ff.irq_en;
				default: nxt_st.rdata = 8'h00;
			endcase
		end
		nxt_st.irq = |(nxt_st.irq_stat & nxt_st.irq_en);
		nxt_st.rc_en = wd_en | i_fail_safe_clock_monitor_enable;
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_ff <= '0;
			st_ff.soft_en <= wdcm_pkg::RST_SOFT_EN;
			st_ff.irq_en <= wdcm_pkg::RST_IRQ_EN;
			st_ff.to_flag <= 1'b1;
			st_ff.pd_flag <= 1'b1;
		end
		else if (i_ce)
		begin
			st_ff <= nxt_st;
		end
	end

	// outputs straight from the state register
	assign o_rdata = st_ff.rdata;
	assign o_device_reset = st_ff.rst_out;
	assign o_rc_osc_enable = st_ff.rc_en;
	assign o_use_internal_osc = st_ff.failsafe;
	assign o_timeout_status_flag = st_ff.to_flag;
	assign o_powerdown_status_flag = st_ff.pd_flag;
	assign o_irq = st_ff.irq;

	// checks
	a_rc_osc_on: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce |=> o_rc_osc_enable == $past(wd_en || i_fail_safe_clock_monitor_enable))
		else $error("rc oscillator enable does not follow watchdog or monitor");
	a_rc_stays_monitor: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_fail_safe_clock_monitor_enable && !wd_en |=> o_rc_osc_enable)
		else $error("rc oscillator stopped while monitor enabled");
	a_base_bound: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		st_ff.base_cnt < 16'(BASE_TICKS))
		else $error("base counter passed its period");
	a_ps_bound: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		!$changed(i_wdog_postscale_select) && wd_en
		|-> st_ff.ps_cnt <= wdcm_ps_limit(i_wdog_postscale_select))
		else $error("postscaler passed its selected limit");
	a_instr_clears: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && (i_clear_wdog_instruction || i_sleep_instruction)
		|=> st_ff.base_cnt == 16'h0000 && st_ff.ps_cnt == '0)
		else $error("instruction did not clear the watchdog");
	a_counts_on_tick: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && rc_tick && !ctr_clear && !base_end
		|=> st_ff.base_cnt == $past(st_ff.base_cnt) + 16'h0001)
		else $error("enabled watchdog failed to count");
	a_soft_disabled: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		!i_config_wdog_enable && !st_ff.soft_en |-> !timeout ##1 !o_device_reset)
		else $error("disabled watchdog produced a reset");
	a_fail_effects: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && fail_det |=> st_ff.irq_stat[wdcm_pkg::FLAG_OSC_FAIL] && o_use_internal_osc
		&& st_ff.ps_cnt == '0 && st_ff.base_cnt == 16'h0000)
		else $error("clock failure effects missing");
	a_no_intosc_fail: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_clk_src_is_intosc |-> !fail_det)
		else $error("internal oscillator failure was flagged");
	a_timeout_reset: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && timeout |=> o_device_reset && !o_timeout_status_flag
		&& st_ff.irq_stat[wdcm_pkg::FLAG_WDOG_TO])
		else $error("time-out gave no device reset");
	a_clear_wdog_instruction_flags: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_clear_wdog_instruction |=> o_timeout_status_flag && o_powerdown_status_flag)
		else $error("clear-watchdog did not set status flags");
	a_ctrl_readback: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_rd && i_addr == wdcm_pkg::ADDR_CTRL
		|=> o_rdata[wdcm_pkg::CTRL_SOFT_EN] == $past(st_ff.soft_en))
		else $error("control read does not show software enable");

	// reset output, counters, enables, fail-safe mode, status and interrupt flags, read data

	// the device reset lasts exactly one core cycle
	a_reset_one_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && o_device_reset |=> !o_device_reset)
		else $error("device reset longer than one cycle");

	// the device reset follows a time-out and nothing else
	a_reset_from_timeout: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce |=> o_device_reset == $past(timeout))
		else $error("device reset without a time-out");

	// a time-out restarts both counters from zero
	a_timeout_restarts: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && timeout
		|=> st_ff.base_cnt == 16'h0000 && st_ff.ps_cnt == '0)
		else $error("counters not restarted after time-out");

	// the end of a base period advances the postscaler by one
	a_ps_steps: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && rc_tick && base_end && !ctr_clear && !timeout
		|=> st_ff.ps_cnt == $past(st_ff.ps_cnt) + PW'(1) && st_ff.base_cnt == 16'h0000)
		else $error("postscaler did not advance at base period end");

	// without an rc tick or a clear the counters hold
	a_idle_hold: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && !rc_tick && !ctr_clear
		|=> $stable(st_ff.base_cnt) && $stable(st_ff.ps_cnt))
		else $error("watchdog counted without an rc tick");

	// a disabled watchdog keeps both counters at zero
	a_disabled_zero: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && !wd_en
		|=> st_ff.base_cnt == 16'h0000 && st_ff.ps_cnt == '0)
		else $error("disabled watchdog kept a count");

	// the configuration enable cannot be overruled by software
	a_config_overrides: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_config_wdog_enable |=> o_rc_osc_enable)
		else $error("configuration enabled watchdog was stopped");

	// a control write loads the software enable bit
	a_soft_write: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_wr && i_addr == wdcm_pkg::ADDR_CTRL
		|=> st_ff.soft_en == $past(i_wdata[wdcm_pkg::CTRL_SOFT_EN]))
		else $error("software enable not written");

	// the core level bit reads zero while the regulator is off
	a_level_gated: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_rd && i_addr == wdcm_pkg::ADDR_CTRL && !i_regulator_enable
		|=> !o_rdata[wdcm_pkg::CTRL_CORE_LVL])
		else $error("core level shown with regulator off");

	// read data is zero outside the cycle after a read
	a_rdata_idle: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && !i_rd |=> o_rdata == 8'h00)
		else $error("read data present without a read");

	// fail-safe mode holds until the next reset
	a_failsafe_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_use_internal_osc |=> o_use_internal_osc)
		else $error("fail-safe mode left without reset");

	// fail-safe mode is entered only through a detected failure
	a_failsafe_cause: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && !o_use_internal_osc |=> !o_use_internal_osc || $past(fail_det))
		else $error("fail-safe mode entered without a failure");

	// no second failure while already on the internal oscillator
	a_no_refail: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_use_internal_osc |-> !fail_det)
		else $error("failure detected while in fail-safe mode");

	// the oscillator-fail flag stays until software clears it
	a_fail_flag_sticky: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && st_ff.irq_stat[wdcm_pkg::FLAG_OSC_FAIL]
		&& !(i_wr && i_addr == wdcm_pkg::ADDR_CLR && i_wdata[wdcm_pkg::FLAG_OSC_FAIL])
		|=> st_ff.irq_stat[wdcm_pkg::FLAG_OSC_FAIL])
		else $error("oscillator-fail flag lost without a clear");

	// the interrupt is high only while an enabled flag is set
	a_irq_source: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		o_irq |-> |(st_ff.irq_stat & st_ff.irq_en))
		else $error("interrupt without an enabled flag");

	// sleep sets time-out status and clears power-down status
	a_sleep_flags: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && i_sleep_instruction && !i_clear_wdog_instruction
		|=> o_timeout_status_flag && !o_powerdown_status_flag)
		else $error("sleep did not update status flags");

	// an instruction in the cycle of the last tick still wins over the time-out
	a_clear_no_reset: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && (i_clear_wdog_instruction || i_sleep_instruction) |=> !o_device_reset)
		else $error("time-out despite a clear in the same cycle");

	// the rc oscillator is off when nobody needs it
	a_rc_off_idle: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		i_ce && !i_config_wdog_enable && !st_ff.soft_en && !i_fail_safe_clock_monitor_enable
		|=> !o_rc_osc_enable)
		else $error("rc oscillator on with watchdog and monitor off");

	// the longest select counts 32768 base periods
	a_ps_longest: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
		wdcm_ps_limit(wdcm_pkg::SEL_WIDTH'(15)) == PW'(32767))
		else $error("longest postscale ratio is wrong");
endmodule

// *** wdcm_core_model.sv ***
// Purpose: processor core and rc oscillator model facing the watchdog
// Assumes: bench requests are one-cycle levels on the core clock
// Notes: rc pin rests low while the oscillator is off
`timescale 1ns/1ps
module wdcm_core_model (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_rc_enable,
	input wire logic i_clear_req,
	input wire logic i_sleep_req,
	output logic o_clear,
	output logic o_sleep,
	output logic o_rc_osc
);
	logic [2:0] div_ff;
	// instructions retire a cycle after the request; rc half period is 5 cycles
	always_ff @(posedge i_core_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_clear <= 1'b0;
			o_sleep <= 1'b0;
			o_rc_osc <= 1'b0;
			div_ff <= 3'h0;
		end
		else
		begin
			o_clear <= i_clear_req;
			o_sleep <= i_sleep_req;
			if (!i_rc_enable)
			begin
				o_rc_osc <= 1'b0;
				div_ff <= 3'h0;
			end
			else if (div_ff == 3'h4)
			begin
				o_rc_osc <= ~o_rc_osc;
				div_ff <= 3'h0;
			end
			else
				div_ff <= div_ff + 3'h1;
		end
	end
endmodule

// *** tb_watchdog_with_clock_fail_reset.sv ***
// Purpose: self-checking bench for the watchdog with clock-fail reset
// Assumes: base period shortened to 4 rc ticks, postscale select 1
// Notes: the core model issues instructions and runs the rc pin
`timescale 1ns/1ps
module tb_watchdog_with_clock_fail_reset;
	logic clk, rstn, wr, rd, crq, srq, cl, sl, rc, rc_q, cfg, fail_safe_clock_monitor, ios, reg_en, smp, lat, lvl;
	logic [3:0] addr, sel;
	logic [7:0] wdata, rdata, d;
	logic drst, rc_en, use_int, to_f, pd_f, irq;
	int num_errors, checks_done, rises, rsts;
	wdcm_core_model core (.i_core_clk(clk), .i_rstn(rstn), .i_rc_enable(rc_en),
		.i_clear_req(crq), .i_sleep_req(srq), .o_clear(cl), .o_sleep(sl), .o_rc_osc(rc));
	wdcm_top #(.BASE_TICKS(4)) dut (.i_core_clk(clk), .i_rstn(rstn), .i_ce(1'b1),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .i_clear_wdog_instruction(cl),
		.i_sleep_instruction(sl), .i_config_wdog_enable(cfg), .i_wdog_postscale_select(sel),
		.i_fail_safe_clock_monitor_enable(fail_safe_clock_monitor), .i_clk_src_is_intosc(ios), .i_regulator_enable(reg_en),
		.i_internal_rc_osc(rc), .i_sample_clk(smp), .i_monitor_latch(lat),
		.i_core_supply_level(lvl), .o_rdata(rdata), .o_device_reset(drst),
		.o_rc_osc_enable(rc_en), .o_use_internal_osc(use_int), .o_timeout_status_flag(to_f),
		.o_powerdown_status_flag(pd_f), .o_irq(irq));
	// 50 MHz core clock
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// count rc rises and reset pulses
	always @(posedge clk)
	begin
		rc_q <= rc;
		if (rc === 1'b1 && rc_q === 1'b0)
			rises++;
		if (drst === 1'b1)
			rsts++;
	end
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("counts: %0d checks, %0d mismatches", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic wreg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_rst();
		for (int i = 0; i < 400; i++)
		begin
			@(posedge clk);
			#1;
			if (drst === 1'b1)
				return;
		end
		num_errors++;
		$display("[ERR] device reset expected 1 seen 0");
		tally_and_finish();
	endtask
	task automatic pulse(input bit slp);
		@(posedge clk);
		if (slp)
			srq <= 1'b1;
		else
			crq <= 1'b1;
		@(posedge clk);
		srq <= 1'b0;
		crq <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	// register defaults, unmapped read, regulator gating of the level bit
	task automatic t_reset();
		rreg(4'h0);
		chk("ctrl", d, 8'h18);
		rreg(4'h3);
		chk("irq enables", d, 8'h00);
		rreg(4'hf);
		chk("unmapped", d, 8'h00);
		chk("rc enable", rc_en, 8'h00);
		reg_en <= 1'b1;
		repeat (6) @(posedge clk);
		rreg(4'h0);
		chk("ctrl level", d, 8'h58);
		reg_en <= 1'b0;
		$display("test reset done");
	endtask
	// software enable, full time-out, flag and interrupt
	task automatic t_timeout();
		wreg(4'h3, 8'h01);
		#1 rises = 0;
		wreg(4'h0, 8'h01);
		wait_rst();
		chk("rc enable", rc_en, 8'h01);
		chk("ticks", rises[7:0], 8'h08);
		chk("to flag", to_f, 8'h00);
		rreg(4'h1);
		chk("flags", d, 8'h01);
		chk("irq", irq, 8'h01);
		wreg(4'h2, 8'h01);
		repeat (2) @(posedge clk);
		chk("irq cleared", irq, 8'h00);
		$display("test timeout done");
	endtask
	// clear instruction sets status bits and keeps the watchdog quiet
	task automatic t_clear();
		pulse(1'b0);
		rreg(4'h0);
		chk("ctrl", d, 8'h19);
		#1 rsts = 0;
		repeat (6)
		begin
			repeat (25) @(posedge clk);
			pulse(1'b0);
		end
		chk("resets", rsts[7:0], 8'h00);
		$display("test clear done");
	endtask
	// sleep restarts the count and the watchdog still runs
	task automatic t_sleep();
		pulse(1'b1);
		chk("pd flag", pd_f, 8'h00);
		chk("to flag", to_f, 8'h01);
		#1 rises = 0;
		wait_rst();
		chk("ticks", 8'((rises >= 7) && (rises <= 8)), 8'h01);
		$display("test sleep done");
	endtask
	// configuration enable overrides software disable
	task automatic t_config();
		wreg(4'h0, 8'h00);
		cfg <= 1'b1;
		wait_rst();
		chk("rc enable", rc_en, 8'h01);
		cfg <= 1'b0;
		repeat (3) @(posedge clk);
		chk("rc off", rc_en, 8'h00);
		$display("test config done");
	endtask
	// clock monitor: ignored on internal osc, then a real failure
	task automatic t_fail();
		wreg(4'h3, 8'h80);
		fail_safe_clock_monitor <= 1'b1;
		ios <= 1'b1;
		lat <= 1'b1;
		smp <= 1'b1;
		repeat (8) @(posedge clk);
		chk("rc on", rc_en, 8'h01);
		smp <= 1'b0;
		repeat (10) @(posedge clk);
		rreg(4'h1);
		chk("no fail", d & 8'h80, 8'h00);
		ios <= 1'b0;
		smp <= 1'b1;
		repeat (8) @(posedge clk);
		smp <= 1'b0;
		repeat (10) @(posedge clk);
		rreg(4'h1);
		chk("fail flag", d & 8'h80, 8'h80);
		chk("int osc", use_int, 8'h01);
		chk("irq", irq, 8'h01);
		wreg(4'h2, 8'h80);
		repeat (2) @(posedge clk);
		chk("irq cleared", irq, 8'h00);
		$display("test fail done");
	endtask
	// main sequence
	initial
	begin
		{rstn, wr, rd, crq, srq, cfg, fail_safe_clock_monitor, ios, reg_en, smp, lat, rc_q} = '0;
		{addr, sel, wdata, d} = '0;
		lvl = 1'b1;
		{num_errors, checks_done, rises, rsts} = '0;
		sel = 4'h1;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_timeout();
		t_clear();
		t_sleep();
		t_config();
		t_fail();
		tally_and_finish();
	end
endmodule
